// ==== design/iwds_pkg.sv ====
// Package with instruction fields, opcodes and sequencing constants for the decoder
package iwds_pkg;
    localparam int IWDS_WORD_W = 14;
    localparam int IWDS_FADDR_W = 7;
    localparam int IWDS_PC_W = 13;
    localparam int IWDS_PHASES = 4;
    localparam int IWDS_LIT8_W = 8;
    localparam int IWDS_LIT11_W = 11;
    // Special file addresses
    localparam logic [6:0] IWDS_ADDR_TIMER = 7'h01;
    localparam logic [6:0] IWDS_ADDR_PORTA = 7'h05;
    localparam logic [6:0] IWDS_ADDR_PORTB = 7'h06;
    localparam logic [6:0] IWDS_ADDR_PORTC = 7'h07;
    localparam logic [12:0] IWDS_PC_RST = 13'h0000;
    localparam logic [7:0] IWDS_ACC_RST = 8'h00;
    // Byte-op function codes (word bits 11:8)
    localparam logic [3:0] IWDS_F_MOVWF = 4'h0;
    localparam logic [3:0] IWDS_F_CLR = 4'h1;
    localparam logic [3:0] IWDS_F_SUB = 4'h2;
    localparam logic [3:0] IWDS_F_DEC = 4'h3;
    localparam logic [3:0] IWDS_F_IOR = 4'h4;
    localparam logic [3:0] IWDS_F_AND = 4'h5;
    localparam logic [3:0] IWDS_F_XOR = 4'h6;
    localparam logic [3:0] IWDS_F_ADD = 4'h7;
    localparam logic [3:0] IWDS_F_MOV = 4'h8;
    localparam logic [3:0] IWDS_F_COM = 4'h9;
    localparam logic [3:0] IWDS_F_INC = 4'ha;
    localparam logic [3:0] IWDS_F_DECSZ = 4'hb;
    localparam logic [3:0] IWDS_F_RRF = 4'hc;
    localparam logic [3:0] IWDS_F_RLF = 4'hd;
    localparam logic [3:0] IWDS_F_SWAP = 4'he;
    localparam logic [3:0] IWDS_F_INCSZ = 4'hf;
    // Control words
    localparam logic [13:0] IWDS_W_RETURN = 14'h0008;
    localparam logic [13:0] IWDS_W_RETFIE = 14'h0009;
    localparam logic [13:0] IWDS_W_SLEEP = 14'h0063;
    localparam logic [13:0] IWDS_W_CLRWDT = 14'h0064;

    typedef enum logic [1:0] {
        IWDS_CLS_BYTE = 2'b00,
        IWDS_CLS_BIT = 2'b01,
        IWDS_CLS_LIT = 2'b10
    } iwds_class_t;

    typedef enum logic [1:0] {
        IWDS_ST_EXEC = 2'b00,
        IWDS_ST_FLUSH = 2'b01
    } iwds_state_t;
endpackage

// ==== design/iwds_field_if.sv ====
// Interface carrying the decoded fields from the field decoder to the sequencer
`timescale 1ns/1ps
interface iwds_field_if;
    import iwds_pkg::*;
    iwds_class_t cls;
    logic [3:0] func;
    logic dest;
    logic [6:0] faddr;
    logic [2:0] bitsel;
    logic [1:0] bitop;
    logic [7:0] lit8;
    logic [10:0] lit11;
    modport dec (output cls, func, dest, faddr, bitsel, bitop, lit8, lit11);
    modport seq (input cls, func, dest, faddr, bitsel, bitop, lit8, lit11);
endinterface

// ==== design/iwds_field_dec.sv ====
// Combinational split of one instruction word into class and operand fields
`timescale 1ns/1ps
module iwds_field_dec
    import iwds_pkg::*;
(
    input wire logic [iwds_pkg::IWDS_WORD_W-1:0] word,
    iwds_field_if.dec fld
);
    import iwds_pkg::*;

    // Top two bits pick the class; 10 and 11 are both literal/control
    always_comb begin
        if (word[13:12] == 2'b00) begin
            fld.cls = IWDS_CLS_BYTE;
        end else if (word[13:12] == 2'b01) begin
            fld.cls = IWDS_CLS_BIT;
        end else begin
            fld.cls = IWDS_CLS_LIT;
        end
    end

    // Operand fields at fixed positions
    assign fld.func = word[11:8];
    assign fld.dest = word[7];
    assign fld.faddr = word[6:0];
    assign fld.bitsel = word[9:7];
    assign fld.bitop = word[11:10];
    assign fld.lit8 = word[7:0];
    assign fld.lit11 = word[10:0];
endmodule

// ==== design/iwds_seq.sv ====
// Instruction decode and read-modify-write sequencer, top level
// Function
// - Accept 14-bit words split into opcode and operand fields.
// - Classify each word as byte, bit, or literal/control operation.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - File address field spans 0x00 to 0x7F within the bank.
// - Bit field selects one bit of the addressed 8-bit register.
// - Literal is 8 bits for data, 11 bits for jump/call.
// - Don't-care bits never change the decoded result.
// - One instruction cycle is four oscillator periods.
// - One cycle per instruction; taken skip or branch adds a no-op cycle.
// - File operands are read, modified, then stored, even for clears.
// - Read of the change-detect port refreshes its compare state.
// - Port register reads return pin levels, not output latches.
// - Writing the first timer count clears an assigned prescaler.
`timescale 1ns/1ps
module iwds_seq
    import iwds_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [iwds_pkg::IWDS_WORD_W-1:0] instr_word,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] port_pins,
    input wire logic prescaler_on_timer,
    input wire logic [12:0] stack_top,
    output logic [12:0] program_counter,
    output logic [1:0] phase,
    output logic [6:0] file_addr,
    output logic file_rd,
    output logic file_rd_port,
    output logic file_wr,
    output logic [7:0] file_wdata,
    output logic port_change_refresh,
    output logic prescaler_clr,
    output logic stack_push,
    output logic stack_pop,
    output logic [7:0] acc,
    output logic carry,
    output logic zero,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic wdt_clear,
    output logic discard,
    output logic [1:0] instr_class
);
    import iwds_pkg::*;

    iwds_field_if fld();
    iwds_field_dec u_dec (
        .word(instr_word),
        .fld(fld)
    );

    logic [1:0] phase_ff, nxt_phase;
    iwds_state_t state_ff, nxt_state;
    logic [12:0] pc_ff, nxt_pc;
    logic [7:0] acc_ff, nxt_acc;
    logic [7:0] rd_ff, nxt_rd;
    logic carry_ff, nxt_carry, zero_ff, nxt_zero;
    logic to_ff, nxt_to, pd_ff, nxt_pd;
    logic [7:0] pins_s1_ff, pins_s2_ff;

    // Pin levels pass two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_ff <= 8'h00;
            pins_s2_ff <= 8'h00;
        end else begin
            pins_s1_ff <= port_pins;
            pins_s2_ff <= pins_s1_ff;
        end
    end

    logic is_port;
    logic [7:0] opnd, opnd_live;
    assign is_port = (fld.faddr == IWDS_ADDR_PORTA) || (fld.faddr == IWDS_ADDR_PORTB) ||
                     (fld.faddr == IWDS_ADDR_PORTC);
    // Port operands come from pins
    assign opnd_live = is_port ? pins_s2_ff : file_rdata;
    // Modify step works on the value latched at the read, not a later one
    assign opnd = rd_ff;

    logic exec;
    assign exec = (state_ff == IWDS_ST_EXEC);

    // Result computation for the current word
    logic [7:0] res, bmask;
    logic [8:0] sum;
    logic wr_f, wr_w, upd_z, upd_c, taken, c_out, reads_f, push, pop;
    logic [12:0] tgt;
    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        wr_f = 1'b0;
        wr_w = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        c_out = carry_ff;
        taken = 1'b0;
        reads_f = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        tgt = pc_ff + 13'h0001;
        bmask = 8'h01 << fld.bitsel;
        case (fld.cls)
            IWDS_CLS_BYTE: begin
                if (fld.func == IWDS_F_MOVWF && !fld.dest) begin
                    // Return words match exactly; other words here, bar sleep and watchdog clear, act as no-ops
                    if (instr_word[6:0] == IWDS_W_RETURN[6:0] ||
                        instr_word[6:0] == IWDS_W_RETFIE[6:0]) begin
                        taken = 1'b1;
                        pop = 1'b1;
                        tgt = stack_top;
                    end
                end else begin
                    reads_f = 1'b1;
                    sum = 9'h000;
                    case (fld.func)
                        IWDS_F_MOVWF: res = acc_ff;
                        IWDS_F_CLR: res = 8'h00;
                        IWDS_F_SUB: sum = {1'b0, opnd} + {1'b0, ~acc_ff} + 9'h001;
                        IWDS_F_DEC: res = opnd - 8'h01;
                        IWDS_F_IOR: res = opnd | acc_ff;
                        IWDS_F_AND: res = opnd & acc_ff;
                        IWDS_F_XOR: res = opnd ^ acc_ff;
                        IWDS_F_ADD: sum = {1'b0, opnd} + {1'b0, acc_ff};
                        IWDS_F_MOV: res = opnd;
                        IWDS_F_COM: res = ~opnd;
                        IWDS_F_INC: res = opnd + 8'h01;
                        IWDS_F_DECSZ: res = opnd - 8'h01;
                        IWDS_F_RRF: {res, c_out} = {carry_ff, opnd};
                        IWDS_F_RLF: {c_out, res} = {opnd, carry_ff};
                        IWDS_F_SWAP: res = {opnd[3:0], opnd[7:4]};
                        IWDS_F_INCSZ: res = opnd + 8'h01;
                        default: res = opnd;
                    endcase
                    if (fld.func == IWDS_F_ADD || fld.func == IWDS_F_SUB) begin
                        res = sum[7:0];
                        c_out = sum[8];
                        upd_c = 1'b1;
                    end
                    upd_c = upd_c || fld.func == IWDS_F_RRF || fld.func == IWDS_F_RLF;
                    upd_z = !(fld.func inside {IWDS_F_MOVWF, IWDS_F_DECSZ, IWDS_F_INCSZ,
                                               IWDS_F_RRF, IWDS_F_RLF, IWDS_F_SWAP});
                    // Destination select: 0 to accumulator, 1 back to the file
                    wr_f = fld.dest;
                    wr_w = !fld.dest;
                    if (fld.func == IWDS_F_DECSZ || fld.func == IWDS_F_INCSZ) begin
                        taken = (res == 8'h00);
                        tgt = pc_ff + 13'h0002;
                    end
                end
            end
            IWDS_CLS_BIT: begin
                reads_f = 1'b1;
                case (fld.bitop)
                    2'b00: begin
                        res = opnd & ~bmask;
                        wr_f = 1'b1;
                    end
                    2'b01: begin
                        res = opnd | bmask;
                        wr_f = 1'b1;
                    end
                    2'b10: taken = ((opnd & bmask) == 8'h00);
                    default: taken = ((opnd & bmask) != 8'h00);
                endcase
                if (taken) begin
                    tgt = pc_ff + 13'h0002;
                end
            end
            default: begin
                if (instr_word[13:12] == 2'b10) begin
                    taken = 1'b1;
                    push = !instr_word[11];
                    tgt = {pc_ff[12:11], fld.lit11};
                end else begin
                    wr_w = 1'b1;
                    case (instr_word[11:9])
                        3'b000, 3'b001: res = fld.lit8; // Bits 9:8 are don't-care
                        3'b010, 3'b011: begin
                            res = fld.lit8;
                            taken = 1'b1;
                            pop = 1'b1;
                            tgt = stack_top;
                        end
                        3'b100: begin
                            upd_z = 1'b1;
                            case (instr_word[8])
                                1'b0: res = fld.lit8 | acc_ff;
                                default: res = fld.lit8 & acc_ff;
                            endcase
                        end
                        3'b101: begin
                            upd_z = 1'b1;
                            res = fld.lit8 ^ acc_ff;
                            if (instr_word[8]) begin
                                wr_w = 1'b0;
                                upd_z = 1'b0;
                            end
                        end
                        3'b110: begin
                            sum = {1'b0, fld.lit8} + {1'b0, ~acc_ff} + 9'h001;
                            res = sum[7:0];
                            c_out = sum[8];
                            upd_c = 1'b1;
                            upd_z = 1'b1;
                        end
                        default: begin
                            sum = {1'b0, fld.lit8} + {1'b0, acc_ff};
                            res = sum[7:0];
                            c_out = sum[8];
                            upd_c = 1'b1;
                            upd_z = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    logic last_ph;
    assign last_ph = (phase_ff == 2'd3);
    logic is_sleep, is_clrwdt;
    assign is_sleep = (instr_word == IWDS_W_SLEEP);
    assign is_clrwdt = (instr_word == IWDS_W_CLRWDT);

    // Phase counter, skip state, PC, accumulator and status update
    always_comb begin
        nxt_phase = phase_ff + 2'd1;
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_acc = acc_ff;
        nxt_rd = rd_ff;
        nxt_carry = carry_ff;
        nxt_zero = zero_ff;
        nxt_to = to_ff;
        nxt_pd = pd_ff;
        if (phase_ff == 2'd1) begin
            nxt_rd = opnd_live;
        end
        if (last_ph) begin
            if (exec) begin
                nxt_pc = taken ? tgt : pc_ff + 13'h0001;
                nxt_state = taken ? IWDS_ST_FLUSH : IWDS_ST_EXEC;
                if (wr_w) begin
                    nxt_acc = res;
                end
                if (upd_z) begin
                    nxt_zero = (res == 8'h00);
                end
                if (upd_c) begin
                    nxt_carry = c_out;
                end
                if (is_sleep) begin
                    nxt_to = 1'b1;
                    nxt_pd = 1'b0;
                end else if (is_clrwdt) begin
                    nxt_to = 1'b1;
                    nxt_pd = 1'b1;
                end
            end else begin
                // Flushed word: PC, accumulator and status flags hold; state returns to execute
                nxt_state = IWDS_ST_EXEC;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 2'd0;
            state_ff <= IWDS_ST_EXEC;
            pc_ff <= IWDS_PC_RST;
            acc_ff <= IWDS_ACC_RST;
            rd_ff <= 8'h00;
            carry_ff <= 1'b0;
            zero_ff <= 1'b0;
            to_ff <= 1'b1;
            pd_ff <= 1'b1;
        end else begin
            phase_ff <= nxt_phase;
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            rd_ff <= nxt_rd;
            carry_ff <= nxt_carry;
            zero_ff <= nxt_zero;
            to_ff <= nxt_to;
            pd_ff <= nxt_pd;
        end
    end

    // Register file strobes: read in phase 1, write in phase 3
    assign file_addr = fld.faddr;
    assign file_rd = exec && reads_f && (phase_ff == 2'd1);
    assign file_rd_port = file_rd && is_port;
    assign port_change_refresh = file_rd && (fld.faddr == IWDS_ADDR_PORTB);
    assign file_wr = exec && wr_f && last_ph;
    assign file_wdata = res;
    assign prescaler_clr = file_wr && (fld.faddr == IWDS_ADDR_TIMER) && prescaler_on_timer;
    assign stack_push = exec && push && last_ph;
    assign stack_pop = exec && pop && last_ph;
    assign wdt_clear = exec && (is_sleep || is_clrwdt) && last_ph;
    assign discard = !exec;
    assign instr_class = fld.cls;
    assign program_counter = pc_ff;
    assign phase = phase_ff;
    assign acc = acc_ff;
    assign carry = carry_ff;
    assign zero = zero_ff;
    assign timeout_flag = to_ff;
    assign powerdown_flag = pd_ff;

    property p_phase_wrap;
        @(posedge mclk) disable iff (!rst_n) last_ph |=> phase_ff == 2'd0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase not four long");

    property p_write_last;
        @(posedge mclk) disable iff (!rst_n) file_wr |-> phase_ff == 2'd3;
    endproperty
    a_write_last: assert property (p_write_last) else $error("write outside final phase");

    property p_read_first;
        @(posedge mclk) disable iff (!rst_n) file_wr |-> $past(file_rd, 2);
    endproperty
    a_read_first: assert property (p_read_first) else $error("write without prior read");

    property p_flush_quiet;
        @(posedge mclk) disable iff (!rst_n) discard |-> !file_wr && !stack_push && !stack_pop;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet) else $error("flushed word had effect");

    property p_taken_flush;
        @(posedge mclk) disable iff (!rst_n) exec && last_ph && taken |=> discard [*4];
    endproperty
    a_taken_flush: assert property (p_taken_flush) else $error("no no-op cycle");

    property p_prescaler;
        @(posedge mclk) disable iff (!rst_n)
            prescaler_clr |-> file_addr == IWDS_ADDR_TIMER && file_wr;
    endproperty
    a_prescaler: assert property (p_prescaler) else $error("bad prescaler clear");

    property p_sleep_flags;
        @(posedge mclk) disable iff (!rst_n)
            exec && last_ph && is_sleep |=> !powerdown_flag && timeout_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_dest_acc;
        @(posedge mclk) disable iff (!rst_n)
            exec && last_ph && fld.cls == IWDS_CLS_BYTE && !fld.dest && reads_f
            |-> !file_wr;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("d=0 wrote file");

    property p_refresh;
        @(posedge mclk) disable iff (!rst_n) port_change_refresh |-> file_rd_port;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh without port read");

    c_skip: cover property (@(posedge mclk) exec && last_ph && taken);
    c_port_rmw: cover property (@(posedge mclk) file_rd_port ##2 file_wr);
    c_timer_wr: cover property (@(posedge mclk) prescaler_clr);
endmodule

// ==== tb/iwds_prog_mem.sv ====
// Program memory model that hands out one instruction word per word address
`timescale 1ns/1ps
module iwds_prog_mem (
    input wire logic [12:0] program_counter,
    output logic [iwds_pkg::IWDS_WORD_W-1:0] instr_word
);
    import iwds_pkg::*;

    logic [IWDS_WORD_W-1:0] mem [0:(1 << IWDS_PC_W)-1];

    // Unwritten locations hold the all-zero no-op word
    initial begin
        for (int i = 0; i < (1 << IWDS_PC_W); i++) begin
            mem[i] = '0;
        end
    end

    // Word follows the fetch address, held while the address holds
    assign instr_word = mem[program_counter];
endmodule

// ==== tb/iwds_seq_bench.sv ====
// Self-checking bench for the instruction decode sequencer
`timescale 1ns/1ps
module iwds_seq_bench;
    import iwds_pkg::*;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] instr_word;
    logic [7:0] file_rdata = 8'h11;
    logic [7:0] port_pins = 8'hc3;
    logic prescaler_on_timer = 1'b0;
    logic [12:0] stack_top = 13'h0123;
    logic [12:0] program_counter;
    logic [1:0] phase, instr_class, cls;
    logic [6:0] file_addr, wa;
    logic [7:0] file_wdata, acc, wd, ph;
    logic file_rd, file_rd_port, file_wr, port_change_refresh, prescaler_clr;
    logic timeout_flag, powerdown_flag, wdt_clear, discard;
    logic stack_push, stack_pop, carry, zero;
    int cnt [9];
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [13:0] prog [12] = '{14'h335a, 14'h00a0, 14'h0186, 14'h0806, 14'h0aff, 14'h0081,
        14'h0181, 14'h17a0, 14'h1c20, 14'h00a1, 14'h3033, 14'h2840};

    // Oscillator period of 25 ns
    always #12.5 mclk = ~mclk;

    iwds_prog_mem iwds_prog_mem_i (
        .program_counter(program_counter),
        .instr_word(instr_word)
    );

    iwds_seq iwds_seq_i (
        .mclk(mclk), .rst_n(rst_n), .instr_word(instr_word), .file_rdata(file_rdata),
        .port_pins(port_pins), .prescaler_on_timer(prescaler_on_timer),
        .stack_top(stack_top), .program_counter(program_counter), .phase(phase),
        .file_addr(file_addr), .file_rd(file_rd), .file_rd_port(file_rd_port),
        .file_wr(file_wr), .file_wdata(file_wdata),
        .port_change_refresh(port_change_refresh), .prescaler_clr(prescaler_clr),
        .stack_push(stack_push), .stack_pop(stack_pop), .acc(acc), .carry(carry),
        .zero(zero),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .wdt_clear(wdt_clear), .discard(discard), .instr_class(instr_class)
    );

    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One instruction cycle, sampled at each falling edge from phase 0 on
    task automatic cyc;
        cnt = '{default: 0};
        ph = 8'h00;
        cls = instr_class;
        repeat (4) begin
            ph = {ph[5:0], phase};
            cnt[0] += int'(file_rd === 1'b1);
            cnt[1] += int'(file_wr === 1'b1);
            cnt[2] += int'(file_rd_port === 1'b1);
            cnt[3] += int'(port_change_refresh === 1'b1);
            cnt[4] += int'(prescaler_clr === 1'b1);
            cnt[5] += int'(discard === 1'b1);
            cnt[6] += int'(wdt_clear === 1'b1);
            cnt[7] += int'(stack_push === 1'b1);
            cnt[8] += int'(stack_pop === 1'b1);
            if (file_wr === 1'b1) begin
                wa = file_addr;
                wd = file_wdata;
            end
            @(negedge mclk);
        end
    endtask

    // Hang guard well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        #1;
        foreach (prog[i]) iwds_prog_mem_i.mem[i] = prog[i];
        iwds_prog_mem_i.mem[13'h040] = 14'h0063;
        iwds_prog_mem_i.mem[13'h041] = 14'h0064;
        iwds_prog_mem_i.mem[13'h042] = 14'h3ed0;
        iwds_prog_mem_i.mem[13'h043] = 14'h2050;
        iwds_prog_mem_i.mem[13'h050] = 14'h0008;
        repeat (4) @(negedge mclk);
        chk(program_counter, 13'h0000);
        chk(acc, 8'h00);
        chk({timeout_flag, powerdown_flag}, 2'h3);
        chk(phase, 2'h0);
        rst_n = 1'b1;
        // Literal load with both don't-care bits set
        cyc;
        chk(ph, 8'h1b);
        chk(cls, 2'h2);
        chk(acc, 8'h5a);
        chk(program_counter, 13'h0001);
        chk(cnt[5], 0);
        // Accumulator stored to file 0x20
        cyc;
        chk(cls, 2'h0);
        chk(cnt[0], 1);
        chk(cnt[1], 1);
        chk(wa, 7'h20);
        chk(wd, 8'h5a);
        // Clear of the change-detect port still reads it first
        cyc;
        chk(cnt[0], 1);
        chk(cnt[3], 1);
        chk(cnt[2], 1);
        chk(wd, 8'h00);
        // Port moved to accumulator takes pin levels
        cyc;
        chk(acc, 8'hc3);
        chk(cnt[1], 0);
        // Increment of the top file address written back
        file_rdata = 8'h7f;
        cyc;
        chk(wa, 7'h7f);
        chk(wd, 8'h80);
        chk(acc, 8'hc3);
        // Timer writes with prescaler assigned, then unassigned
        file_rdata = 8'h11;
        prescaler_on_timer = 1'b1;
        cyc;
        chk(cnt[4], 1);
        prescaler_on_timer = 1'b0;
        cyc;
        chk(cnt[4], 0);
        chk(cnt[1], 1);
        // Bit 7 set on file 0x20
        cyc;
        chk(cls, 2'h1);
        chk(wd, 8'h91);
        // Taken bit test skips, then the flushed cycle stays silent
        cyc;
        chk(cnt[1], 0);
        chk(program_counter, 13'h000a);
        cyc;
        chk(cnt[5], 4);
        chk(cnt[0] + cnt[1], 0);
        chk(acc, 8'hc3);
        chk(program_counter, 13'h000a);
        cyc;
        chk(acc, 8'h33);
        // Jump with eleven-bit target then flush
        cyc;
        chk(program_counter, 13'h0040);
        cyc;
        chk(cnt[5], 4);
        chk(program_counter, 13'h0040);
        chk({timeout_flag, powerdown_flag}, 2'h3);
        chk(cnt[6], 0);
        // Power-down then watchdog clear update the status flags
        cyc;
        chk({timeout_flag, powerdown_flag}, 2'h2);
        chk(cnt[6], 1);
        cyc;
        chk({timeout_flag, powerdown_flag}, 2'h3);
        // Literal add overflows: carry set, zero cleared
        cyc;
        chk(acc, 8'h03);
        chk({carry, zero}, 2'h2);
        // Call pushes once, then return pops to the stack top
        cyc;
        chk(cnt[7], 1);
        chk(program_counter, 13'h0050);
        cyc;
        chk(cnt[5], 4);
        chk(cnt[7] + cnt[8], 0);
        cyc;
        chk(cnt[8], 1);
        chk(program_counter, 13'h0123);
        cyc;
        chk(cnt[5], 4);
        chk(program_counter, 13'h0123);
        close_out();
    end
endmodule
